// ### core/dmadp_core.sv
// dmadp_core.sv: data-pointer pair, data address decode, external bus control
// assumes the cpu core drives one request per cycle, synchronous inputs
// What this block does
// - strobe free runs unless suppress bit set
// - two 16-bit pointers, one select bit
// - incrementing pointer control toggles select only
// - pointer control bit 2 reads zero
// - pointer instructions use selected pointer
// - active pointer bytes are sfr readable/writable
// - 00H-7FH is lower ram, any mode
// - above 7FH: direct sfr, indirect upper ram
// - bypass clear: moves below 0200H hit xram
// - xram access leaves port 0, read and write strobes idle
// - bypass clear: higher addresses use external bus
// - bypass set: index move drives 8-bit address
// - bypass set: pointer move drives 16 bits
// - write strobe on p3.6, read on p3.7
// - stack stays in 256-byte internal ram
`include "dmadp_cfg.svh"
`default_nettype none
module dmadp_core (
	// clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst,
	// sfr access from the core
	input  wire logic                       sfr_wr,
	input  wire logic                       sfr_inc,
	input  wire logic [7:0]                 sfr_addr,
	input  wire logic [7:0]                 sfr_wdata,
	output var  logic [7:0]                 sfr_rdata,
	// pointer instructions
	input  wire dmadp_pkg::dmadp_ptr_op_type ptr_op,
	input  wire logic [15:0]                ptr_imm,
	output var  logic [15:0]                mem_pointer,
	// internal data address decode
	input  wire logic [7:0]                 int_addr,
	input  wire logic                       int_indirect,
	input  wire logic                       int_stack,
	output var  dmadp_pkg::dmadp_seg_type    int_seg,
	// external move request
	input  wire logic                       xmove,
	input  wire logic                       xmove_wr,
	input  wire logic                       xmove_use_ptr,
	input  wire logic [7:0]                 xmove_index,
	input  wire logic [7:0]                 xmove_wdata,
	input  wire logic                       code_move,
	output var  logic [7:0]                 xram_rdata,
	output var  logic                       xram_hit,
	// external bus pins
	input  wire logic [7:0]                 port_zero_bus_in,
	output var  logic [7:0]                 port_zero_bus_out,
	output var  logic                       port_zero_bus_oe,
	output var  logic [7:0]                 port_two_bus,
	output var  logic                       addr_strobe,
	output var  logic                       write_strobe_pin_n,
	output var  logic                       read_strobe_pin_n,
	output var  logic [7:0]                 ext_rdata
);
	import dmadp_pkg::*;

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic        strobe_suppress;
	logic        onchip_xram_bypass;
	logic [7:0]  aux_pointer_control;
	logic [15:0] mem_pointer_a;
	logic [15:0] mem_pointer_b;
	logic [7:0]  port_two_sfr;
	logic        pointer_select;
	logic [2:0]  strobe_cnt;
	logic [15:0] x_addr;
	logic        ext_cycle;
	logic [7:0]  next_aux_ptr;

	assign pointer_select = aux_pointer_control[`DMADP_BIT_SELECT];

	// increment on bit 2 fixed zero carries into bit 3 never: bit 2 held 0
	always_comb begin
		next_aux_ptr = aux_pointer_control;
		if (sfr_inc && sfr_addr == `DMADP_AUX_PTR_ADDR) begin
			next_aux_ptr = aux_pointer_control + 8'h01;
		end else if (sfr_wr && sfr_addr == `DMADP_AUX_PTR_ADDR) begin
			next_aux_ptr = sfr_wdata;
		end
		next_aux_ptr[`DMADP_BIT_FIXED_ZERO] = 1'b0;
		next_aux_ptr[1] = 1'b0;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aux_pointer_control <= `DMADP_BYTE_RESET;
		end else begin
			aux_pointer_control <= next_aux_ptr;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			strobe_suppress    <= 1'b0;
			onchip_xram_bypass <= 1'b0;
			port_two_sfr       <= `DMADP_BYTE_RESET;
		end else if (sfr_wr && sfr_addr == `DMADP_AUX_BUS_ADDR) begin
			strobe_suppress    <= sfr_wdata[`DMADP_BIT_SUPPRESS];
			onchip_xram_bypass <= sfr_wdata[`DMADP_BIT_BYPASS];
		end else if (sfr_wr && sfr_addr == `DMADP_P2_ADDR) begin
			port_two_sfr <= sfr_wdata;
		end
	end

	// ------------------------------------------------------------
	// pointer pair
	// ------------------------------------------------------------
	logic [15:0] next_ptr;
	always_comb begin
		next_ptr = mem_pointer;
		unique case (ptr_op)
			DMADP_OP_INC:  next_ptr = mem_pointer + 16'h0001;
			DMADP_OP_LOAD: next_ptr = ptr_imm;
			DMADP_OP_NONE, DMADP_OP_RD, DMADP_OP_WR,
			DMADP_OP_CODE, DMADP_OP_JMP: next_ptr = mem_pointer;
			default:       next_ptr = mem_pointer;
		endcase
		if (sfr_wr && sfr_addr == `DMADP_PTR_LOW_ADDR) begin
			next_ptr[7:0] = sfr_wdata;
		end
		if (sfr_wr && sfr_addr == `DMADP_PTR_HIGH_ADDR) begin
			next_ptr[15:8] = sfr_wdata;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mem_pointer_a <= `DMADP_PTR_RESET;
			mem_pointer_b <= `DMADP_PTR_RESET;
		end else if (pointer_select) begin
			mem_pointer_b <= next_ptr;
		end else begin
			mem_pointer_a <= next_ptr;
		end
	end

	assign mem_pointer = pointer_select ? mem_pointer_b : mem_pointer_a;

	// ------------------------------------------------------------
	// sfr read mux
	// ------------------------------------------------------------
	always_comb begin
		unique case (sfr_addr)
			`DMADP_AUX_BUS_ADDR:  sfr_rdata = {6'h00, onchip_xram_bypass,
				strobe_suppress};
			`DMADP_AUX_PTR_ADDR:  sfr_rdata = aux_pointer_control;
			`DMADP_PTR_LOW_ADDR:  sfr_rdata = mem_pointer[7:0];
			`DMADP_PTR_HIGH_ADDR: sfr_rdata = mem_pointer[15:8];
			`DMADP_P2_ADDR:       sfr_rdata = port_two_sfr;
			default:              sfr_rdata = 8'h00;
		endcase
	end

	// ------------------------------------------------------------
	// internal data decode
	// ------------------------------------------------------------
	always_comb begin
		if (int_addr <= `DMADP_LOW_TOP) begin
			int_seg = DMADP_SEG_LOW;
		end else if (int_indirect || int_stack) begin
			int_seg = DMADP_SEG_UPPER;
		end else begin
			int_seg = DMADP_SEG_SFR;
		end
	end

	// ------------------------------------------------------------
	// external move routing
	// ------------------------------------------------------------
	assign x_addr = xmove_use_ptr ? mem_pointer : {port_two_sfr, xmove_index};
	assign xram_hit = xmove && !onchip_xram_bypass &&
		x_addr <= `DMADP_XRAM_TOP;
	assign ext_cycle = xmove && !xram_hit;

	dmadp_xram u_xram (
		.clk   (clk),
		.en    (xram_hit),
		.we    (xmove_wr),
		.addr  (x_addr[8:0]),
		.wdata (xmove_wdata),
		.rdata (xram_rdata)
	);

	// address phase cycle, then data phase cycle with the strobe low
	logic ext_addr_phase;
	logic ext_data_phase;
	logic ext_wr_q;
	logic [7:0] ext_wdata_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ext_addr_phase <= 1'b0;
			ext_data_phase <= 1'b0;
			ext_wr_q       <= 1'b0;
			ext_wdata_q    <= 8'h00;
			port_zero_bus_out <= 8'h00;
			port_two_bus   <= 8'h00;
			ext_rdata      <= 8'h00;
		end else begin
			ext_addr_phase <= ext_cycle;
			ext_data_phase <= ext_addr_phase;
			if (ext_cycle) begin
				ext_wr_q    <= xmove_wr;
				ext_wdata_q <= xmove_wdata;
			end
			if (ext_cycle) begin
				port_zero_bus_out <= x_addr[7:0];
			end else if (ext_addr_phase && ext_wr_q) begin
				port_zero_bus_out <= ext_wdata_q;
			end
			// p2 holds the high pointer byte through the data phase
			if (ext_cycle && xmove_use_ptr) begin
				port_two_bus <= mem_pointer[15:8];
			end else if (!ext_addr_phase) begin
				port_two_bus <= port_two_sfr;
			end
			if (ext_data_phase && !ext_wr_q) begin
				ext_rdata <= port_zero_bus_in;
			end
		end
	end

	logic p0_drive;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			p0_drive <= 1'b0;
		end else begin
			p0_drive <= ext_cycle || (ext_addr_phase && ext_wr_q);
		end
	end
	assign port_zero_bus_oe = p0_drive;

	assign write_strobe_pin_n = !(ext_data_phase && ext_wr_q);
	assign read_strobe_pin_n  = !(ext_data_phase && !ext_wr_q);

	// ------------------------------------------------------------
	// address latch strobe
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			strobe_cnt <= 3'h0;
		end else if (strobe_cnt == `DMADP_STROBE_LAST) begin
			strobe_cnt <= 3'h0;
		end else begin
			strobe_cnt <= strobe_cnt + 3'h1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			addr_strobe <= 1'b0;
		end else if (strobe_suppress) begin
			addr_strobe <= ext_cycle || code_move;
		end else begin
			addr_strobe <= strobe_cnt == 3'h0;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	chk_inc_toggle: assert property (@(posedge clk) disable iff (rst)
		sfr_inc && sfr_addr == `DMADP_AUX_PTR_ADDR && !sfr_wr |=>
		pointer_select != $past(pointer_select) &&
		aux_pointer_control[7:3] == $past(aux_pointer_control[7:3]))
		else $error("pointer select did not toggle cleanly");
	chk_bit2_zero: assert property (@(posedge clk) disable iff (rst)
		aux_pointer_control[`DMADP_BIT_FIXED_ZERO] == 1'b0)
		else $error("pointer control bit 2 not zero");
	chk_ptr_inc: assert property (@(posedge clk) disable iff (rst)
		ptr_op == DMADP_OP_INC && !sfr_wr && !sfr_inc |=>
		mem_pointer == $past(mem_pointer) + 16'h0001)
		else $error("selected pointer did not increment");
	chk_ptr_other: assert property (@(posedge clk) disable iff (rst)
		ptr_op == DMADP_OP_LOAD && !sfr_inc && !sfr_wr && !pointer_select
		|=> mem_pointer_b == $past(mem_pointer_b))
		else $error("unselected pointer changed");
	chk_seg_low: assert property (@(posedge clk) disable iff (rst)
		int_addr <= `DMADP_LOW_TOP |-> int_seg == DMADP_SEG_LOW)
		else $error("low ram decode wrong");
	chk_seg_upper: assert property (@(posedge clk) disable iff (rst)
		int_addr > `DMADP_LOW_TOP && !int_indirect && !int_stack
		|-> int_seg == DMADP_SEG_SFR)
		else $error("direct upper access missed sfr space");
	chk_xram_quiet: assert property (@(posedge clk) disable iff (rst)
		xram_hit |=> write_strobe_pin_n && read_strobe_pin_n &&
		!port_zero_bus_oe)
		else $error("xram access disturbed the bus");
	chk_route_hit: assert property (@(posedge clk) disable iff (rst)
		xmove && !onchip_xram_bypass && x_addr[15:9] == 7'h00 |-> xram_hit)
		else $error("low move not routed to xram");
	chk_wr_strobe: assert property (@(posedge clk) disable iff (rst)
		ext_cycle && xmove_wr |-> ##2 !write_strobe_pin_n && read_strobe_pin_n)
		else $error("write strobe missing");
	chk_strobe_rate: assert property (@(posedge clk) disable iff (rst)
		!strobe_suppress && addr_strobe && !$past(strobe_suppress)
		##1 !strobe_suppress[*5] |-> ##1 addr_strobe)
		else $error("strobe not one in six");
	chk_p2_ptr: assert property (@(posedge clk) disable iff (rst)
		ext_cycle && xmove_use_ptr |=> port_two_bus == $past(mem_pointer[15:8]))
		else $error("port 2 lacks pointer high byte");
endmodule
`default_nettype wire

// ### core/dmadp_cfg.svh
// dmadp_cfg.svh: register addresses, bit positions, reset values, timing
// assumes inclusion by the design files only
`ifndef DMADP_CFG_SVH
`define DMADP_CFG_SVH
`define DMADP_AUX_BUS_ADDR      8'h8E
`define DMADP_AUX_PTR_ADDR      8'hA2
`define DMADP_PTR_LOW_ADDR      8'h82
`define DMADP_PTR_HIGH_ADDR     8'h83
`define DMADP_P2_ADDR           8'hA0
`define DMADP_BIT_SUPPRESS      0
`define DMADP_BIT_BYPASS        1
`define DMADP_BIT_SELECT        0
`define DMADP_BIT_FIXED_ZERO    2
`define DMADP_PTR_WR_MASK       8'hFB
`define DMADP_PTR_RESET         16'h0000
`define DMADP_BYTE_RESET        8'h00
`define DMADP_XRAM_TOP          16'h01FF
`define DMADP_XRAM_WORDS        512
`define DMADP_LOW_TOP           8'h7F
`define DMADP_STROBE_PERIOD     3'h6
`define DMADP_STROBE_LAST       3'h5
`endif

// ### core/dmadp_pkg.sv
// dmadp_pkg.sv: types shared by the addressing block
// assumes dmadp_cfg.svh on the include path
`default_nettype none
package dmadp_pkg;
	typedef enum logic [2:0] {
		DMADP_OP_NONE,
		DMADP_OP_INC,
		DMADP_OP_LOAD,
		DMADP_OP_RD,
		DMADP_OP_WR,
		DMADP_OP_CODE,
		DMADP_OP_JMP
	} dmadp_ptr_op_type;
	typedef enum logic [1:0] {
		DMADP_SEG_LOW,
		DMADP_SEG_UPPER,
		DMADP_SEG_SFR
	} dmadp_seg_type;
endpackage
`default_nettype wire

// ### core/dmadp_xram.sv
// dmadp_xram.sv: on-chip expanded data ram, 512 bytes
// assumes one clock; read data registered one cycle after the request
`include "dmadp_cfg.svh"
`default_nettype none
module dmadp_xram (
	// clock
	input  wire logic       clk,
	// access
	input  wire logic       en,
	input  wire logic       we,
	input  wire logic [8:0] addr,
	input  wire logic [7:0] wdata,
	output var  logic [7:0] rdata
);
	logic [7:0] mem [0:`DMADP_XRAM_WORDS-1];

	always_ff @(posedge clk) begin
		if (en && we) begin
			mem[addr] <= wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (en && !we) begin
			rdata <= mem[addr];
		end
	end
endmodule
`default_nettype wire

// ### verif/dmadp_ext_mem.sv
// dmadp_ext_mem.sv: external data memory on the multiplexed bus
// assumes address phase is the first cycle that port zero is driven
`default_nettype none
module dmadp_ext_mem (
	// clock
	input  wire logic       clk,
	// multiplexed bus
	input  wire logic [7:0] p0_out,
	input  wire logic       p0_oe,
	input  wire logic [7:0] p2,
	input  wire logic       wr_n,
	input  wire logic       rd_n,
	output var  logic [7:0] p0_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]  mem [0:65535];
	logic [15:0] addr = 16'h0000;
	logic        oe_q = 1'b0;
	logic        wr_seen = 1'b0;
	logic [7:0]  last = 8'h5A;
	always @(posedge clk) begin
		if (p0_oe && !oe_q) begin
			addr <= {p2, p0_out};
			wr_seen <= 1'b0;
		end
		if (!wr_n) begin
			mem[addr] <= p0_out;
			wr_seen <= 1'b1;
		end
		oe_q <= p0_oe;
		if (!rd_n)
			last <= mem[addr];
	end
	// released bus shows no stale byte
	always_comb p0_in = !rd_n ? mem[addr] : ~last;
endmodule
`default_nettype wire

// ### verif/tb.sv
// tb.sv: self-checking bench for the addressing block
// assumes dmadp_pkg compiled first, partner in dmadp_ext_mem.sv
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import dmadp_pkg::*;
	logic clk = 0, rst = 1, sfr_wr = 0, sfr_inc = 0, xmove = 0, xmove_wr = 0;
	logic xmove_use_ptr = 0, code_move = 0, int_indirect = 0, int_stack = 0;
	logic [7:0] sfr_addr = 0, sfr_wdata = 0, int_addr = 0, xmove_index = 0;
	logic [7:0] xmove_wdata = 0, sfr_rdata, xram_rdata, ext_rdata, p0i, p0o;
	logic [7:0] p2, d, aux_m;
	logic [15:0] ptr_imm = 0, mem_pointer, pm[2];
	dmadp_ptr_op_type ptr_op = DMADP_OP_NONE;
	dmadp_seg_type int_seg;
	logic xram_hit, p0oe, ale, wr_n, rd_n, sel;
	logic [7:0] mem_m [int];
	logic [7:0] regs [4] = '{8'h8E, 8'hA2, 8'h82, 8'h83};
	logic [31:0] v;
	int err_count = 0, n_checks = 0, cnt, seed;
	dmadp_core uut (.clk(clk), .rst(rst), .sfr_wr(sfr_wr), .sfr_inc(sfr_inc),
		.sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.ptr_op(ptr_op), .ptr_imm(ptr_imm), .mem_pointer(mem_pointer),
		.int_addr(int_addr), .int_indirect(int_indirect), .int_stack(int_stack),
		.int_seg(int_seg), .xmove(xmove), .xmove_wr(xmove_wr),
		.xmove_use_ptr(xmove_use_ptr), .xmove_index(xmove_index),
		.xmove_wdata(xmove_wdata), .code_move(code_move),
		.xram_rdata(xram_rdata), .xram_hit(xram_hit), .port_zero_bus_in(p0i),
		.port_zero_bus_out(p0o), .port_zero_bus_oe(p0oe), .port_two_bus(p2),
		.addr_strobe(ale), .write_strobe_pin_n(wr_n),
		.read_strobe_pin_n(rd_n), .ext_rdata(ext_rdata));
	dmadp_ext_mem ext (.clk(clk), .p0_out(p0o), .p0_oe(p0oe), .p2(p2),
		.wr_n(wr_n), .rd_n(rd_n), .p0_in(p0i));
	initial begin
		forever #12.5 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task end_of_test;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task tick;
		@(posedge clk);
		#2;
	endtask
	task sfr_w(input logic [7:0] a, dd);
		sfr_addr = a;
		sfr_wdata = dd;
		sfr_wr = 1;
		tick;
		sfr_wr = 0;
	endtask
	task sfr_r(input logic [7:0] a);
		sfr_addr = a;
		#1 d = sfr_rdata;
	endtask
	task ptr_do(input dmadp_ptr_op_type op, input logic [15:0] imm);
		ptr_op = op;
		ptr_imm = imm;
		tick;
		ptr_op = DMADP_OP_NONE;
	endtask
	task automatic xm(input logic wr, up, hit, input logic [7:0] idx,
		input logic [15:0] a);
		xmove = 1;
		xmove_wr = wr;
		xmove_use_ptr = up;
		xmove_index = idx;
		xmove_wdata = v[7:0];
		#1 chk("xram_hit", xram_hit, hit);
		tick;
		xmove = 0;
		if (hit) begin
			chk("p0_oe", p0oe, 0);
			chk("wr_n", wr_n, 1);
			chk("rd_n", rd_n, 1);
			if (!wr) chk("xram_rdata", xram_rdata, mem_m[a]);
		end else begin
			chk("p0 addr", p0o, a[7:0]);
			chk("p2 addr", p2, a[15:8]);
			tick;
			if (wr) chk("wr_n", wr_n, 0);
			if (!wr) chk("rd_n", rd_n, 0);
			tick;
			if (!wr) chk("ext_rdata", ext_rdata, mem_m[a]);
		end
		if (wr) mem_m[a] = v[7:0];
		tick;
		tick;
	endtask
	task automatic pair(input logic up, hit, input logic [7:0] idx,
		input logic [15:0] a);
		v = $urandom;
		if (up) ptr_do(DMADP_OP_LOAD, a);
		xm(1, up, hit, idx, a);
		xm(0, up, hit, idx, a);
	endtask
	initial begin
		#2000000;
		err_count++;
		end_of_test;
	end
	initial begin
		seed = $urandom(32'h6e9674fb);
		repeat (8) @(posedge clk);
		#2 rst = 0;
		foreach (regs[i]) begin
			sfr_r(regs[i]);
			chk("reset sfr", d, 0);
		end
		// free-running strobe, then suppressed
		cnt = 0;
		repeat (60) begin
			tick;
			cnt += ale;
		end
		chk("strobe count", cnt, 10);
		sfr_w(8'h8E, 8'h01);
		cnt = 0;
		repeat (30) begin
			tick;
			cnt += ale;
		end
		chk("suppressed count", cnt, 0);
		code_move = 1;
		tick;
		code_move = 0;
		repeat (6) begin
			cnt += ale;
			tick;
		end
		chk("code move strobe", cnt, 1);
		pm = '{16'h0000, 16'h0000};
		for (int i = 0; i < 6; i++) begin
			v = $urandom;
			sfr_w(8'hA2, v[7:0]);
			aux_m = v[7:0] & 8'hF9;
			sfr_r(8'hA2);
			chk("ptr ctrl", d, aux_m);
			sel = aux_m[0];
			sfr_w(8'h82, v[15:8]);
			sfr_w(8'h83, v[23:16]);
			pm[sel] = v[23:8];
			chk("mem_pointer", mem_pointer, pm[sel]);
			ptr_do(DMADP_OP_LOAD, i == 0 ? 16'hFFFF : v[31:16]);
			ptr_do(DMADP_OP_INC, 0);
			pm[sel] = (i == 0 ? 16'hFFFF : v[31:16]) + 16'h1;
			for (int k = 3; k < 7; k++)
				ptr_do(dmadp_ptr_op_type'(k), 16'h1234);
			chk("mem_pointer", mem_pointer, pm[sel]);
			sfr_r(8'h83);
			chk("ptr high", d, pm[sel][15:8]);
			sfr_addr = 8'hA2;
			sfr_inc = 1;
			tick;
			sfr_inc = 0;
			sfr_r(8'hA2);
			chk("ptr ctrl inc", d, aux_m ^ 8'h01);
			chk("other ptr", mem_pointer, pm[!sel]);
		end
		for (int j = 0; j < 40; j++) begin
			v = $urandom;
			int_addr = j < 2 ? 8'h7F + j[7:0] : v[7:0];
			int_indirect = v[8];
			int_stack = v[9];
			#1 chk("int_seg", 16'(int_seg), int_addr <= 8'h7F ? DMADP_SEG_LOW :
				(int_indirect || int_stack) ? DMADP_SEG_UPPER
				: DMADP_SEG_SFR);
			tick;
		end
		sfr_w(8'h8E, 8'h00);
		sfr_w(8'hA0, 8'h01);
		pair(1, 1, 0, 16'h01FF);
		pair(1, 0, 0, 16'h0200);
		pair(0, 1, 8'h23, 16'h0123);
		sfr_w(8'h8E, 8'h02);
		sfr_w(8'hA0, 8'h9C);
		pair(0, 0, 8'h23, 16'h9C23);
		pair(1, 0, 0, 16'h0100);
		rst = 1;
		tick;
		rst = 0;
		sfr_r(8'hA2);
		chk("reset ctrl", d, 0);
		chk("reset pointer", mem_pointer, 0);
		end_of_test;
	end
endmodule
`default_nettype wire
